// ==== logic/sdd_defines.svh ====
// Purpose: Constants for the delta-sigma input decimation path
// Assumes: 40 MHz system clock
// Notes:   Widths, ratios, counts, reset values, clock period and request codes only; types live in the package
`ifndef SDD_DEFINES_SVH
`define SDD_DEFINES_SVH
`define SDD_SAMPLE_W        24
`define SDD_OSR_BASE        128
`define SDD_OSR_MID         64
`define SDD_OSR_HIGH        32
`define SDD_FILTER_DELAY    63
`define SDD_FIFO_DEPTH      32
`define SDD_CHANNELS        2
`define SDD_CH_W            1
`define SDD_ALIAS_RST_PRIM  1'b1
`define SDD_ALIAS_RST_OTHER 1'b0
`define SDD_CLK_PERIOD_NS   25
`define SDD_REQ_HALF        2'h0
`define SDD_REQ_NOT_EMPTY   2'h1
`define SDD_REQ_QUARTER     2'h2
`define SDD_REQ_FULL        2'h3
`endif

// ==== logic/sdd_pkg.sv ====
// Purpose: Types for the delta-sigma input decimation path
// Assumes: sdd_defines.svh holds the numbers
// Notes:   Band codes follow increasing sample rate
package sdd_pkg;
   typedef enum logic [1:0] {
      SDD_BAND_LOW  = 2'b00,
      SDD_BAND_MID  = 2'b01,
      SDD_BAND_HIGH = 2'b10
   } sdd_band_t;
   typedef enum logic [1:0] {
      SDD_ST_IDLE  = 2'b00,
      SDD_ST_SKIP  = 2'b01,
      SDD_ST_RUN   = 2'b10
   } sdd_state_t;
   typedef struct packed {
      logic        chan;
      logic [23:0] data;
   } sdd_sample_t;
   typedef struct packed {
      sdd_band_t  band;
      logic [3:0] extra_log2;
      logic       alias_en;
      logic       align_en;
   } sdd_cfg_t;
endpackage

// ==== logic/sdd_fifo.sv ====
// Purpose: Shared input FIFO, flip-flop storage
// Assumes: One clock, synchronous active-high reset
// Notes:   Level output feeds the request condition
`timescale 1ns/1ps
module sdd_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // Fill level
   output logic      [AW:0]      level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             push;
   logic             pop;
   assign in_ready  = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         level <= level + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== logic/sdd_decim.sv ====
// Purpose: Delta-sigma input decimation path, modulator bits to 24-bit samples
// Assumes: Modulator bits arrive synchronous to clk_sys with a per-bit strobe
// Notes:   Third-order CIC; cut-off scales with the rate since it is a sinc^3
//          of length equal to the oversample ratio
//
// Summary of operation
// - Modulator runs at power-of-two multiple of output rate, 128 in base case.
// - Filter turns 1-bit stream into 24-bit samples at the selected rate.
// - Low-pass cut-off scales with sample rate, following output Nyquist.
// - Oversample ratio 32, 64 or 128 by rate band.
// - Alias-reject mode acquires internally at a multiple of the requested rate.
// - Alias-reject mode decimates by the same multiple used for oversampling.
// - Extra decimation factors 32 down to 2 by octave.
// - Optional variant adds extra factors 256, 128 and 64.
// - Alias-reject enable resets on for primary variant, off for others.
// - Without alignment, first samples after trigger include filter-delay presamples.
// - With alignment, first delivered sample lines up with the trigger.
// - All input channels write one common FIFO.
// - Transfer requests follow a selectable FIFO fill condition.
// - USB variant has a fixed request condition.
`timescale 1ns/1ps
`include "sdd_defines.svh"
module sdd_decim
   import sdd_pkg::*;
#(
   parameter int   CHANNELS      = `SDD_CHANNELS,
   parameter int   FIFO_DEPTH    = `SDD_FIFO_DEPTH,
   parameter int   FILTER_DELAY  = `SDD_FILTER_DELAY,
   parameter bit   PRIMARY       = 1'b1,
   parameter bit   WIDE_EXTRA    = 1'b0,
   parameter bit   USB_VARIANT   = 1'b0
) (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     sys_rst,
   // Modulator streams
   input  wire logic                     mod_strobe,
   input  wire logic [CHANNELS-1:0]      mod_bit,
   // Control
   input  wire logic                     acq_start,
   input  wire logic                     acq_stop,
   input  wire logic                     dig_trigger,
   input  wire logic [1:0]               rate_band,
   input  wire logic [3:0]               extra_log2,
   input  wire logic                     alias_cfg_we,
   input  wire logic                     low_rate_alias_reject_en,
   input  wire logic                     trigger_delay_align_en,
   input  wire logic [1:0]               req_cond,
   // Host DMA side
   output logic                          dma_req,
   output logic                          rd_valid,
   input  wire logic                     rd_ready,
   output logic [`SDD_SAMPLE_W:0]        rd_data,
   // Status
   output logic                          acq_running,
   output logic                          alias_reject_state,
   output logic                          overflow
);
   localparam int AW = $clog2(FIFO_DEPTH);

   // ------------------------------------------------------------
   // Configuration latch
   // ------------------------------------------------------------
   sdd_cfg_t   cfg;
   sdd_state_t state;
   logic       alias_en;

   // Enable reset value depends on variant
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         alias_en <= PRIMARY ? `SDD_ALIAS_RST_PRIM : `SDD_ALIAS_RST_OTHER;
      end else if (alias_cfg_we && state == SDD_ST_IDLE) begin
         alias_en <= low_rate_alias_reject_en;
      end
   end

   // Settings sampled at start only, so a running filter never sees them move
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg <= '0;
      end else if (state == SDD_ST_IDLE && acq_start) begin
         cfg.band       <= sdd_band_t'(rate_band);
         cfg.alias_en   <= alias_en && rate_band == 2'h0;
         cfg.extra_log2 <= (!WIDE_EXTRA && extra_log2 > 4'h5) ? 4'h5
                         : (extra_log2 > 4'h8 ? 4'h8
                         : (extra_log2 == 4'h0 ? 4'h1 : extra_log2));
         cfg.align_en   <= trigger_delay_align_en;
      end
   end

   // ------------------------------------------------------------
   // Oversample ratio
   // ------------------------------------------------------------
   logic [7:0] osr_m1;
   always_comb begin
      unique case (cfg.band)
         SDD_BAND_HIGH: osr_m1 = 8'(`SDD_OSR_HIGH - 1);
         SDD_BAND_MID:  osr_m1 = 8'(`SDD_OSR_MID - 1);
         default:       osr_m1 = 8'(`SDD_OSR_BASE - 1);
      endcase
   end

   // ------------------------------------------------------------
   // Third-order CIC per channel, shared phase counter
   // ------------------------------------------------------------
   logic [7:0]  phase;
   logic        dump;
   logic [23:0] acc1 [CHANNELS];
   logic [23:0] acc2 [CHANNELS];
   logic [23:0] acc3 [CHANNELS];
   logic [23:0] d1   [CHANNELS];
   logic [23:0] d2   [CHANNELS];
   logic [23:0] d3   [CHANNELS];
   logic [23:0] cic  [CHANNELS];

   assign dump = mod_strobe && phase == osr_m1 && state != SDD_ST_IDLE;

   always_ff @(posedge clk_sys) begin
      if (sys_rst || state == SDD_ST_IDLE) begin
         phase <= '0;
      end else if (mod_strobe) begin
         phase <= (phase == osr_m1) ? '0 : phase + 8'h01;
      end
   end

   // Sinc^3 of length OSR puts its nulls at multiples of the output rate
   for (genvar c = 0; c < CHANNELS; c++) begin : g_cic
      logic [23:0] c1;
      logic [23:0] c2;
      assign c1     = acc3[c] - d1[c];
      assign c2     = c1 - d2[c];
      assign cic[c] = c2 - d3[c];
      always_ff @(posedge clk_sys) begin
         if (sys_rst || state == SDD_ST_IDLE) begin
            acc1[c] <= '0;
            acc2[c] <= '0;
            acc3[c] <= '0;
            d1[c]   <= '0;
            d2[c]   <= '0;
            d3[c]   <= '0;
         end else if (mod_strobe) begin
            acc1[c] <= acc1[c] + {23'h000000, mod_bit[c]};
            acc2[c] <= acc2[c] + acc1[c];
            acc3[c] <= acc3[c] + acc2[c];
            if (dump) begin
               d1[c] <= acc3[c];
               d2[c] <= c1;
               d3[c] <= c2;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Extra decimation for alias-reject mode
   // ------------------------------------------------------------
   logic [7:0]  ext_cnt;
   logic [7:0]  ext_m1;
   logic        ext_done;
   logic [31:0] ext_sum [CHANNELS];
   logic [23:0] out_word [CHANNELS];
   logic        out_stb;

   assign ext_m1   = cfg.alias_en ? 8'((9'h001 << cfg.extra_log2) - 9'h001) : 8'h00;
   assign ext_done = dump && ext_cnt == ext_m1;

   always_ff @(posedge clk_sys) begin
      if (sys_rst || state == SDD_ST_IDLE) begin
         ext_cnt <= '0;
      end else if (dump) begin
         ext_cnt <= ext_done ? '0 : ext_cnt + 8'h01;
      end
   end

   for (genvar c = 0; c < CHANNELS; c++) begin : g_ext
      logic [31:0] sum_now;
      assign sum_now = ext_sum[c] + {8'h00, cic[c]};
      // Boxcar average over the same factor used to raise the rate
      always_ff @(posedge clk_sys) begin
         if (sys_rst || state == SDD_ST_IDLE) begin
            ext_sum[c]  <= '0;
            out_word[c] <= '0;
         end else if (dump) begin
            ext_sum[c] <= ext_done ? '0 : sum_now;
            if (ext_done) begin
               out_word[c] <= 24'(sum_now >> (cfg.alias_en ? cfg.extra_log2 : 4'h0));
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         out_stb <= 1'b0;
      end else begin
         out_stb <= ext_done;
      end
   end

   // ------------------------------------------------------------
   // Acquisition and trigger alignment
   // ------------------------------------------------------------
   logic [7:0] skip_cnt;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state    <= SDD_ST_IDLE;
         skip_cnt <= '0;
      end else begin
         unique case (state)
            SDD_ST_IDLE: begin
               skip_cnt <= '0;
               if (acq_start) begin
                  state <= SDD_ST_SKIP;
               end
            end
            SDD_ST_SKIP: begin
               if (acq_stop) begin
                  state <= SDD_ST_IDLE;
               end else if (!cfg.align_en && dig_trigger) begin
                  state <= SDD_ST_RUN;
               end else if (cfg.align_en && out_stb && skip_cnt != '0) begin
                  if (skip_cnt == 8'(FILTER_DELAY)) begin
                     state <= SDD_ST_RUN;
                  end
                  skip_cnt <= skip_cnt + 8'h01;
               end else if (cfg.align_en && dig_trigger) begin
                  skip_cnt <= 8'h01;
               end
            end
            SDD_ST_RUN: begin
               if (acq_stop) begin
                  state <= SDD_ST_IDLE;
               end
            end
            default: state <= SDD_ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Channel serialiser into the shared FIFO
   // ------------------------------------------------------------
   logic [CHANNELS-1:0] pend;
   logic                wr_chan;
   logic                fifo_in_ready;
   logic                fifo_out_valid;
   logic [`SDD_SAMPLE_W:0] fifo_out_data;
   logic [AW:0]         level;
   sdd_sample_t         wr_word;

   assign wr_chan = pend[0] ? 1'b0 : 1'b1;
   assign wr_word = '{chan: wr_chan, data: out_word[wr_chan]};

   // A new frame while the previous one is still queued is dropped and flagged
   // Stop also drops a held frame, so nothing stale waits on a full FIFO
   always_ff @(posedge clk_sys) begin
      if (sys_rst || state == SDD_ST_IDLE || acq_stop) begin
         pend     <= '0;
         overflow <= 1'b0;
      end else if (out_stb && state == SDD_ST_RUN) begin
         if (pend != '0) begin
            overflow <= 1'b1;
         end else begin
            pend <= '1;
         end
      end else if (pend != '0 && fifo_in_ready) begin
         pend[wr_chan] <= 1'b0;
      end
   end

   sdd_fifo #(
      .WIDTH (`SDD_SAMPLE_W + 1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (pend != '0),
      .in_ready  (fifo_in_ready),
      .in_data   (wr_word),
      .out_valid (fifo_out_valid),
      .out_ready (rd_ready && rd_valid),
      .out_data  (fifo_out_data),
      .level     (level)
   );

   // ------------------------------------------------------------
   // DMA request and outputs
   // ------------------------------------------------------------
   logic       next_dma_req;
   logic [1:0] cond;
   assign cond = USB_VARIANT ? `SDD_REQ_NOT_EMPTY : req_cond;
   always_comb begin
      unique case (cond)
         `SDD_REQ_NOT_EMPTY: next_dma_req = level != '0;
         `SDD_REQ_QUARTER:   next_dma_req = level >= (AW+1)'(FIFO_DEPTH / 4);
         `SDD_REQ_FULL:      next_dma_req = level == (AW+1)'(FIFO_DEPTH);
         default:            next_dma_req = level >= (AW+1)'(FIFO_DEPTH / 2);
      endcase
   end

   // Registered view of FIFO head; holds until taken so valid/data stay stable
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dma_req            <= 1'b0;
         acq_running        <= 1'b0;
         alias_reject_state <= 1'b0;
         rd_valid           <= 1'b0;
         rd_data            <= '0;
      end else begin
         dma_req            <= next_dma_req;
         acq_running        <= state != SDD_ST_IDLE;
         alias_reject_state <= alias_en;
         if (!rd_valid || rd_ready) begin
            rd_valid <= fifo_out_valid && !(rd_valid && rd_ready);
            rd_data  <= fifo_out_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_alias_reset_value: assert property (@(posedge clk_sys)
      $fell(sys_rst) |-> alias_en == PRIMARY)
      else $error("alias reject enable has wrong reset value");
   a_cfg_stable_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state != SDD_ST_IDLE && $past(state) != SDD_ST_IDLE |-> $stable(cfg))
      else $error("configuration changed during acquisition");
   a_osr_phase_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
      phase <= osr_m1)
      else $error("phase exceeded oversample ratio");
   a_extra_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ext_cnt <= ext_m1)
      else $error("extra decimation counter out of range");
   a_no_extra_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !cfg.alias_en |-> (dump == ext_done))
      else $error("extra decimation active while disabled");
   sequence s_trig_unaligned;
      state == SDD_ST_SKIP && !cfg.align_en && dig_trigger && !acq_stop;
   endsequence
   a_trig_direct: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_trig_unaligned |=> state == SDD_ST_RUN)
      else $error("trigger did not start unaligned run");
   a_align_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state == SDD_ST_RUN && $past(state) == SDD_ST_SKIP && cfg.align_en
      |-> $past(skip_cnt) == 8'(FILTER_DELAY))
      else $error("run began before filter delay was skipped");
   a_req_nonempty: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cond == `SDD_REQ_NOT_EMPTY && level != '0 |=> dma_req)
      else $error("request missing with data in FIFO");
   a_fifo_idle_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pend != '0 |-> state == SDD_ST_RUN)
      else $error("FIFO write outside acquisition");
endmodule

// ==== tb/sdd_host_dma.sv ====
// Purpose: Host DMA reader model for the shared input FIFO
// Assumes: Reads while a request or a word is up; en and slow come from the bench
// Notes:   Logs each word taken with its cycle stamp for the bench to judge
`timescale 1ns/1ps
module sdd_host_dma
   import sdd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Stream from the device
   input  wire logic        dma_req,
   input  wire logic        rd_valid,
   input  wire sdd_sample_t rd_data,
   output logic             rd_ready,
   // Behaviour
   input  wire logic        en,
   input  wire logic        slow
);
   sdd_sample_t q_data[$];
   int          q_cyc[$];
   int          cyc = 0;
   // ----------------------------------------
   // Reader
   // ----------------------------------------
   // Slow mode drops ready every other cycle so the FIFO sees back-pressure
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (sys_rst)
         rd_ready <= 1'b0;
      else
         rd_ready <= en && (dma_req || rd_valid) && !(slow && rd_ready);
      if (!sys_rst && rd_valid && rd_ready) begin
         q_data.push_back(rd_data);
         q_cyc.push_back(cyc);
      end
   end
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the decimation path
// Assumes: Filter delay shortened to 3 frames; one frame is two FIFO words
// Notes:   Frame spacing is measured at the reader, so the reader must be prompt
`timescale 1ns/1ps
module tb;
   import sdd_pkg::*;
   localparam int FD = 3;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        mod_strobe = 1'b0;
   logic        strobe_on = 1'b0;
   logic [1:0]  mod_bit = 2'b01;
   logic        acq_start = 1'b0;
   logic        acq_stop = 1'b0;
   logic        dig_trigger = 1'b0;
   logic [1:0]  rate_band = 2'h0;
   logic [3:0]  extra_log2 = 4'h1;
   logic        alias_cfg_we = 1'b0;
   logic        alias_en = 1'b0;
   logic        align_en = 1'b0;
   logic [1:0]  req_cond = 2'h0;
   logic        host_en = 1'b1;
   logic        host_slow = 1'b0;
   logic        dma_req, rd_valid, rd_ready, acq_running, alias_reject_state, overflow;
   sdd_sample_t rd_data;
   logic        usb_req;
   logic        usb_alias;
   int          n_fail = 0;
   int          compares = 0;
   int          t_trig, t0;
   int          fill_exp[4] = '{16, 2, 8, 34};

   sdd_decim #(.FILTER_DELAY(FD), .WIDE_EXTRA(1'b1)) dut_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .mod_strobe(mod_strobe), .mod_bit(mod_bit),
      .acq_start(acq_start), .acq_stop(acq_stop), .dig_trigger(dig_trigger),
      .rate_band(rate_band), .extra_log2(extra_log2), .alias_cfg_we(alias_cfg_we),
      .low_rate_alias_reject_en(alias_en), .trigger_delay_align_en(align_en),
      .req_cond(req_cond), .dma_req(dma_req), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .acq_running(acq_running),
      .alias_reject_state(alias_reject_state), .overflow(overflow));

   sdd_host_dma host_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .dma_req(dma_req), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_ready(rd_ready), .en(host_en), .slow(host_slow));

   // Second variant: fixed request condition, enable resets off, reader always ready
   sdd_decim #(.FILTER_DELAY(FD), .WIDE_EXTRA(1'b1), .PRIMARY(1'b0), .USB_VARIANT(1'b1)) usb_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .mod_strobe(mod_strobe), .mod_bit(mod_bit),
      .acq_start(acq_start), .acq_stop(acq_stop), .dig_trigger(dig_trigger),
      .rate_band(rate_band), .extra_log2(extra_log2), .alias_cfg_we(alias_cfg_we),
      .low_rate_alias_reject_en(alias_en), .trigger_delay_align_en(align_en),
      .req_cond(req_cond), .dma_req(usb_req), .rd_valid(), .rd_ready(1'b1),
      .rd_data(), .acq_running(), .alias_reject_state(usb_alias), .overflow());

   always #12.5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) mod_strobe <= strobe_on;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic stop_acq();
      @(negedge clk_sys) acq_stop = 1'b1;
      @(negedge clk_sys) acq_stop = 1'b0;
   endtask

   task automatic set_alias(input logic v);
      alias_en = v;
      @(negedge clk_sys) alias_cfg_we = 1'b1;
      @(negedge clk_sys) alias_cfg_we = 1'b0;
      cyc_n(2);
   endtask

   // Settings change only while stopped, so every run stops first
   task automatic run(input logic [1:0] b, input logic [3:0] e, input logic al, input int nw);
      int k;
      strobe_on = 1'b0;
      cyc_n(12);
      stop_acq();
      host_u.q_data.delete();
      host_u.q_cyc.delete();
      rate_band = b;
      extra_log2 = e;
      align_en = al;
      @(negedge clk_sys) acq_start = 1'b1;
      @(negedge clk_sys) acq_start = 1'b0;
      cyc_n(2);
      chk(acq_running, 1'b1);
      @(negedge clk_sys) dig_trigger = 1'b1;
      t_trig = host_u.cyc;
      @(negedge clk_sys) dig_trigger = 1'b0;
      strobe_on = 1'b1;
      k = 0;
      while (host_u.q_data.size() < nw && k < 40000) begin
         @(negedge clk_sys);
         k++;
      end
      chk(k < 40000, 1'b1);
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      int k;
      cyc_n(1);
      chk({dma_req, rd_valid, acq_running, overflow}, 4'h0);
      cyc_n(1);
      sys_rst = 1'b0;
      cyc_n(2);
      chk(alias_reject_state, 1'b1);
      chk(usb_alias, 1'b0);
      chk({dma_req, rd_valid, acq_running, overflow}, 4'h0);
      set_alias(1'b0);
      chk(alias_reject_state, 1'b0);
      // Plain bands: spacing is the oversample ratio, extra factor ignored
      for (int b = 0; b < 3; b++) begin
         run(b[1:0], 4'h1, 1'b0, 10);
         chk(host_u.q_cyc[8] - host_u.q_cyc[6], 128 >> b);
         for (int i = 0; i < 10; i++)
            chk(host_u.q_data[i].chan, i[0]);
         chk(host_u.q_data[8].data, host_u.q_data[6].data);
         chk(host_u.q_data[9].data, host_u.q_data[7].data);
         chk(host_u.q_data[8].data !== host_u.q_data[9].data, 1'b1);
      end
      // Enable writes are refused while running
      alias_en = 1'b1;
      @(negedge clk_sys) alias_cfg_we = 1'b1;
      @(negedge clk_sys) alias_cfg_we = 1'b0;
      cyc_n(2);
      chk(alias_reject_state, 1'b0);
      strobe_on = 1'b0;
      stop_acq();
      set_alias(1'b1);
      chk(alias_reject_state, 1'b1);
      for (int e = 1; e < 7; e++) begin
         run(2'h0, e[3:0], 1'b0, 4);
         chk(host_u.q_cyc[2] - host_u.q_cyc[0], 128 << e);
      end
      run(2'h1, 4'h3, 1'b0, 4);
      chk(host_u.q_cyc[2] - host_u.q_cyc[0], 64);
      strobe_on = 1'b0;
      stop_acq();
      set_alias(1'b0);
      // Trigger alignment moves the first word by the filter delay
      run(2'h2, 4'h1, 1'b0, 2);
      t0 = host_u.q_cyc[0] - t_trig;
      chk(t0 <= 45, 1'b1);
      run(2'h2, 4'h1, 1'b1, 2);
      chk(host_u.q_cyc[0] - t_trig - t0, FD * 32);
      // Fill with the reader stalled, then drain it slowly
      for (int c = 0; c < 4; c++) begin
         strobe_on = 1'b0;
         cyc_n(12);
         host_en = 1'b0;
         req_cond = c[1:0];
         run(2'h2, 4'h1, 1'b0, 0);
         // Fixed variant asks on the first word while the half-full condition still waits
         if (c == 0) begin
            k = 0;
            while (usb_req !== 1'b1 && k < 200) begin
               @(negedge clk_sys);
               k++;
            end
            chk(k < 200, 1'b1);
            chk(dma_req, 1'b0);
         end
         k = 0;
         while (dma_req !== 1'b1 && k < 2000) begin
            @(negedge clk_sys);
            k++;
         end
         strobe_on = 1'b0;
         chk(k < 2000, 1'b1);
         if (c == 3) begin
            strobe_on = 1'b1;
            cyc_n(80);
            strobe_on = 1'b0;
            chk(overflow, 1'b1);
         end
         cyc_n(10);
         chk(rd_valid, 1'b1);
         host_slow = 1'b1;
         host_en = 1'b1;
         cyc_n(120);
         chk(host_u.q_data.size(), fill_exp[c]);
         chk({dma_req, rd_valid}, 2'h0);
         host_slow = 1'b0;
      end
      chk(overflow, 1'b1);
      stop_acq();
      cyc_n(2);
      chk(overflow, 1'b0);
      stop_test();
   end

   // Whole run is about 36k cycles; this limit leaves ample margin
   initial begin
      repeat (95000) @(posedge clk_sys);
      n_fail++;
      stop_test();
   end
endmodule
